// [core/sapc_pkg.sv]
package sapc_pkg;
   // ----------------------------------------------------------------
   // clock and start-up window
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned SW1_WIN_MIN_MS = 500;
   localparam int unsigned SW1_WIN_MAX_MS = 1000;
   // window held to the least figure so the green pin is never driven early
   localparam int unsigned WIN_CYCLES = SW1_WIN_MIN_MS * 1000 * CLK_MHZ;
   // ----------------------------------------------------------------
   // serial framing and register map
   // ----------------------------------------------------------------
   localparam int unsigned BAUD_DIV_DEF = 2170;
   localparam int unsigned BLUE_HOLD_DEF = 1250000;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_TXDATA = 4'h8;
   localparam logic [3:0] ADDR_BAUD = 4'hc;
   localparam int unsigned CTRL_RED_BIT = 0;
   localparam int unsigned CTRL_GREEN_BIT = 1;
   localparam int unsigned CTRL_RTS_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [15:0] BAUD_RESET = 16'h087a;
   localparam int unsigned FIFO_DEPTH = 4;
endpackage

// [core/sapc_fifo.sv]
module sapc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic push;
   logic pop;
   assign o_in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
   assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
   assign o_out_data = mem_reg[rd_ptr_reg[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= '0;
      end else if (push) begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_ptr_reg <= '0;
      end else if (pop) begin
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
      end
   end
   a_fifo_no_overfill: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH))
      else $error("fifo holds more than its depth");
endmodule

// [core/sapc_sync.sv]
module sapc_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= RESET_VAL;
         o_sync <= RESET_VAL;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule

// [core/sapc_pin_ctrl.sv]
// Overview of operation
// - switch 0 low requests external connect
// - both switches low at start-up: factory
// - switch 1 low restores default serial
// - switch 1 honoured only in window
// - green shares pin, driven after window
// - red indicator active low status
// - red pin never sampled as mode
// - blue flickers during transmission
// - rts output, cts input, active low
// - transmit data non-inverted levels
//
// Chosen here: the strobed register port and the placing of the registers.
module sapc_pin_ctrl #(
   parameter int unsigned WIN_CYCLES = sapc_pkg::WIN_CYCLES,
   parameter int unsigned BLUE_HOLD = sapc_pkg::BLUE_HOLD_DEF,
   parameter int unsigned FIFO_DEPTH = sapc_pkg::FIFO_DEPTH
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_sw0_n,
   input wire logic i_sw1_green_n,
   output logic o_green_n,
   output logic o_green_oe,
   output logic o_red_n,
   output logic o_blue_n,
   input wire logic i_cts_n,
   output logic o_rts_n,
   output logic o_txd,
   output logic o_ext_connect,
   output logic o_factory_restore,
   output logic o_serial_default
);
   if (WIN_CYCLES < 2 || BLUE_HOLD < 1 || FIFO_DEPTH < 2) begin : g_bad_param
      $error("bad parameters");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic sw0_s;
   logic sw1_s;
   logic cts_s;
   sapc_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_sw0_n, i_sw1_green_n, i_cts_n}),
      .o_sync({sw0_s, sw1_s, cts_s})
   );

   // ----------------------------------------------------------------
   // start-up window
   // ----------------------------------------------------------------
   logic [31:0] win_cnt_reg;
   logic win_open;
   assign win_open = win_cnt_reg < WIN_CYCLES;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         win_cnt_reg <= '0;
      end else if (win_open) begin
         win_cnt_reg <= win_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_serial_default <= 1'b0;
      end else if (win_open && !sw1_s) begin
         o_serial_default <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_factory_restore <= 1'b0;
      end else if (win_open && !sw1_s && !sw0_s) begin
         o_factory_restore <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ext_connect <= 1'b0;
      end else begin
         o_ext_connect <= !sw0_s;
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   logic [2:0] ctrl_reg;
   logic [15:0] baud_reg;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic tx_busy;
   logic tx_push;
   assign tx_push = i_wr && i_addr == sapc_pkg::ADDR_TXDATA;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg <= sapc_pkg::CTRL_RESET;
      end else if (i_wr && i_addr == sapc_pkg::ADDR_CTRL) begin
         ctrl_reg <= i_wdata[2:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         baud_reg <= sapc_pkg::BAUD_RESET;
      end else if (i_wr && i_addr == sapc_pkg::ADDR_BAUD && i_wdata[15:0] != 16'h0) begin
         baud_reg <= i_wdata[15:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            sapc_pkg::ADDR_CTRL: o_rdata <= {29'h0, ctrl_reg};
            sapc_pkg::ADDR_STATUS: o_rdata <= {24'h0, !win_open, !cts_s, tx_busy,
               fifo_in_ready, o_factory_restore, o_serial_default, !sw1_s, !sw0_s};
            sapc_pkg::ADDR_BAUD: o_rdata <= {16'h0, baud_reg};
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // ----------------------------------------------------------------
   // transmit fifo
   // ----------------------------------------------------------------
   // a write while full is dropped; software polls status bit 4 first
   sapc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(tx_push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_wdata[7:0]),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_out_ready),
      .o_out_data(fifo_out_data)
   );

   // ----------------------------------------------------------------
   // serial transmitter
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SAPC_IDLE, SAPC_SHIFT} sapc_tx_state_t;
   sapc_tx_state_t tx_state_reg;
   logic [9:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [15:0] baud_cnt_reg;
   logic bit_end;
   assign bit_end = baud_cnt_reg == 16'h1;
   assign tx_busy = tx_state_reg == SAPC_SHIFT;
   assign fifo_out_ready = tx_state_reg == SAPC_IDLE && !cts_s;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_state_reg <= SAPC_IDLE;
         shift_reg <= 10'h3ff;
         bit_cnt_reg <= '0;
         baud_cnt_reg <= 16'h1;
      end else begin
         unique case (tx_state_reg)
            SAPC_IDLE: begin
               if (fifo_out_valid && fifo_out_ready) begin
                  shift_reg <= {1'b1, fifo_out_data, 1'b0};
                  bit_cnt_reg <= 4'ha;
                  baud_cnt_reg <= baud_reg;
                  tx_state_reg <= SAPC_SHIFT;
               end
            end
            SAPC_SHIFT: begin
               if (bit_end) begin
                  shift_reg <= {1'b1, shift_reg[9:1]};
                  bit_cnt_reg <= bit_cnt_reg - 4'h1;
                  baud_cnt_reg <= baud_reg;
                  if (bit_cnt_reg == 4'h1) begin
                     tx_state_reg <= SAPC_IDLE;
                  end
               end else begin
                  baud_cnt_reg <= baud_cnt_reg - 16'h1;
               end
            end
            default: tx_state_reg <= SAPC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_txd <= 1'b1;
      end else begin
         o_txd <= tx_busy ? shift_reg[0] : 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rts_n <= 1'b1;
      end else begin
         o_rts_n <= !ctrl_reg[sapc_pkg::CTRL_RTS_BIT];
      end
   end

   // ----------------------------------------------------------------
   // indicators
   // ----------------------------------------------------------------
   // red follows status
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_red_n <= 1'b1;
      end else begin
         o_red_n <= !ctrl_reg[sapc_pkg::CTRL_RED_BIT];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_green_oe <= 1'b0;
         o_green_n <= 1'b1;
      end else begin
         o_green_oe <= !win_open;
         o_green_n <= !ctrl_reg[sapc_pkg::CTRL_GREEN_BIT];
      end
   end

   // blue flicker timer
   // a slow toggle runs while a character is sent, and on to the end of its period, so the flicker is visible
   logic [31:0] blue_cnt_reg;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         blue_cnt_reg <= '0;
         o_blue_n <= 1'b1;
      end else if (tx_busy || blue_cnt_reg != 32'h0) begin
         if (blue_cnt_reg >= BLUE_HOLD - 1) begin
            blue_cnt_reg <= '0;
            o_blue_n <= !o_blue_n;
         end else begin
            blue_cnt_reg <= blue_cnt_reg + 32'h1;
         end
      end else begin
         o_blue_n <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_no_start_cts: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(tx_busy) |-> $past(!cts_s))
      else $error("character started while cts high");
   a_switch_late_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !win_open |=> $stable(o_serial_default))
      else $error("serial default changed after window");
   a_default_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (win_open && !sw1_s) |=> o_serial_default)
      else $error("switch 1 missed in window");
   a_factory_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (win_open && !sw1_s && !sw0_s) |=> o_factory_restore)
      else $error("factory restore missed");
   a_factory_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_factory_restore) |-> $past(!sw0_s && !sw1_s && win_open))
      else $error("factory restore without both switches");
   a_green_hidden: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      win_open |=> !o_green_oe)
      else $error("green driven inside window");
   a_ext_connect: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !sw0_s |=> o_ext_connect)
      else $error("switch 0 not followed");
   a_txd_idle_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !tx_busy |=> o_txd)
      else $error("txd low while idle");
   a_rts_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      ctrl_reg[sapc_pkg::CTRL_RTS_BIT] |=> !o_rts_n)
      else $error("rts not asserted low");
   a_red_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      ctrl_reg[sapc_pkg::CTRL_RED_BIT] |=> !o_red_n)
      else $error("red not driven low");
   a_blue_idle_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!tx_busy && blue_cnt_reg == 32'h0) |=> o_blue_n)
      else $error("blue lit while idle");

   // ----------------------------------------------------------------
   // frame and indicator checks
   // ----------------------------------------------------------------
   // a start is taken only from idle with a byte waiting and cts low
   sequence s_tx_launch;
      tx_state_reg == SAPC_IDLE && fifo_out_valid && fifo_out_ready;
   endsequence
   sequence s_start_bit_out;
      tx_busy ##1 !o_txd;
   endsequence
   sequence s_last_bit_end;
      tx_busy && bit_end && bit_cnt_reg == 4'h1;
   endsequence
   a_start_bit_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      s_tx_launch |=> s_start_bit_out)
      else $error("start bit not driven low");
   a_stop_bit_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      s_last_bit_end |-> o_txd)
      else $error("stop bit not high");
   a_stall_holds_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (cts_s && !tx_busy) |=> !tx_busy)
      else $error("transmitter left idle while cts high");
   a_resume_on_cts: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!cts_s && !tx_busy && fifo_out_valid) |=> tx_busy)
      else $error("waiting byte not started with cts low");
   a_green_driven: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !win_open |=> o_green_oe)
      else $error("green not driven after window");
   a_green_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      ctrl_reg[sapc_pkg::CTRL_GREEN_BIT] |=> !o_green_n)
      else $error("green not driven low");
   a_red_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !ctrl_reg[sapc_pkg::CTRL_RED_BIT] |=> o_red_n)
      else $error("red lit while off");
   a_rts_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !ctrl_reg[sapc_pkg::CTRL_RTS_BIT] |=> o_rts_n)
      else $error("rts asserted while off");
   a_ext_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      sw0_s |=> !o_ext_connect)
      else $error("external connect without switch 0");
   a_default_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_serial_default) |-> $past(win_open && !sw1_s))
      else $error("serial default without switch 1");
   a_window_stays: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !win_open |=> !win_open)
      else $error("start-up window reopened");
   a_blue_toggles: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (tx_busy && blue_cnt_reg >= BLUE_HOLD - 1) |=> $changed(o_blue_n))
      else $error("blue did not flicker while sending");
   a_factory_default: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_factory_restore |-> o_serial_default)
      else $error("factory restore without serial default");
endmodule

// [testbench/sapc_host_model.sv]
module sapc_host_model #(
   parameter int unsigned BAUD = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_txd,
   input wire logic i_stall,
   output logic o_cts_n,
   output logic [31:0] o_bytes,
   output logic [7:0] o_cnt,
   output logic [7:0] o_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // host side of the serial port
   // ----------------------------------------------------------------
   // host drives clear-to-send, active low
   assign o_cts_n = i_stall;
   // low start bit, lsb first, high stop bit
   initial begin
      logic [7:0] rx;
      o_bytes = 32'h0;
      o_cnt = 8'h00;
      o_bad = 8'h00;
      forever begin
         @(negedge i_txd);
         // mid-bit sampling leaves half a bit of margin either way
         repeat (BAUD / 2) @(posedge i_sys_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BAUD) @(posedge i_sys_clk);
            rx[i] = i_txd;
         end
         repeat (BAUD) @(posedge i_sys_clk);
         if (i_txd !== 1'b1)
            o_bad = o_bad + 8'h01;
         o_bytes = {o_bytes[23:0], rx};
         o_cnt = o_cnt + 8'h01;
      end
   end
endmodule

// [testbench/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WIN = 50;
   localparam int unsigned BAUD = 8;
   logic i_sys_clk, i_rst_n, i_wr, i_rd, i_sw0_n, sw1_drv, stall, sw1_pin, blue_prev;
   logic [3:0] i_addr;
   logic [31:0] i_wdata, o_rdata, rx_bytes;
   logic o_green_n, o_green_oe, o_red_n, o_blue_n, cts_n, o_rts_n, o_txd;
   logic o_ext_connect, o_factory_restore, o_serial_default;
   logic [7:0] rx_cnt, rx_bad;
   int error_cnt, n_tests, blue_flips;
   // switch reaches the shared pin only while green is released
   assign sw1_pin = o_green_oe ? o_green_n : sw1_drv;
   sapc_pin_ctrl #(.WIN_CYCLES(WIN), .BLUE_HOLD(4), .FIFO_DEPTH(4)) i_dut (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sw0_n(i_sw0_n),
      .i_sw1_green_n(sw1_pin), .o_green_n(o_green_n), .o_green_oe(o_green_oe),
      .o_red_n(o_red_n), .o_blue_n(o_blue_n), .i_cts_n(cts_n), .o_rts_n(o_rts_n),
      .o_txd(o_txd), .o_ext_connect(o_ext_connect),
      .o_factory_restore(o_factory_restore), .o_serial_default(o_serial_default));
   sapc_host_model #(.BAUD(BAUD)) i_host (
      .i_sys_clk(i_sys_clk), .i_txd(o_txd), .i_stall(stall), .o_cts_n(cts_n),
      .o_bytes(rx_bytes), .o_cnt(rx_cnt), .o_bad(rx_bad));
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      if (o_blue_n !== blue_prev)
         blue_flips++;
      blue_prev <= o_blue_n;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask
   task automatic reset_dut();
      @(posedge i_sys_clk);
      i_rst_n <= 1'b0;
      cycles(2);
      i_rst_n <= 1'b1;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] d;
      chk("idle pins", 32'h1e, {27'h0, o_red_n, o_blue_n, o_rts_n, o_txd, o_green_oe});
      chk("flags", 32'h0, {29'h0, o_ext_connect, o_factory_restore, o_serial_default});
      rd(sapc_pkg::ADDR_CTRL, d);
      chk("ctrl reset", 32'h0, d);
      rd(sapc_pkg::ADDR_BAUD, d);
      chk("baud reset", 32'h087a, d);
      rd(4'h1, d);
      chk("unmapped", 32'h0, d);
      $display("test reset values done");
   endtask
   task automatic t_switch();
      i_sw0_n <= 1'b0;
      sw1_drv <= 1'b0;
      reset_dut();
      cycles(WIN + 10);
      chk("both low", 32'h7, {29'h0, o_ext_connect, o_factory_restore, o_serial_default});
      i_sw0_n <= 1'b1;
      cycles(5);
      chk("sw0 release", 32'h0, {31'h0, o_ext_connect});
      reset_dut();
      cycles(WIN + 10);
      chk("sw1 only", 32'h1, {30'h0, o_factory_restore, o_serial_default});
      sw1_drv <= 1'b1;
      reset_dut();
      cycles(WIN / 2);
      chk("green early", 32'h0, {31'h0, o_green_oe});
      cycles(WIN);
      // green drive pulls the shared pin low after the window
      wr(sapc_pkg::ADDR_CTRL, 32'h2);
      cycles(10);
      chk("green on", 32'h2, {30'h0, o_green_oe, o_green_n});
      chk("late sw1", 32'h0, {31'h0, o_serial_default});
      $display("test switches done");
   endtask
   task automatic t_leds();
      logic [31:0] d;
      logic [2:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 3'(i);
         wr(sapc_pkg::ADDR_CTRL, {29'h0, v});
         rd(sapc_pkg::ADDR_CTRL, d);
         chk("ctrl", {29'h0, v}, d);
         chk("leds", {29'h0, ~v}, {29'h0, o_rts_n, o_green_n, o_red_n});
      end
      wr(sapc_pkg::ADDR_CTRL, 32'h0);
      $display("test indicators done");
   endtask
   task automatic t_tx();
      logic [31:0] d;
      logic low;
      int f0, n;
      stall <= 1'b1;
      wr(sapc_pkg::ADDR_BAUD, 32'h0);
      rd(sapc_pkg::ADDR_BAUD, d);
      chk("baud zero", 32'h087a, d);
      wr(sapc_pkg::ADDR_BAUD, 32'(BAUD));
      f0 = blue_flips;
      // six pushes into four places: the last two are dropped
      for (int i = 0; i < 6; i++)
         wr(sapc_pkg::ADDR_TXDATA, 32'ha0 + 32'(i));
      low = 1'b0;
      for (int i = 0; i < 100; i++) begin
         @(posedge i_sys_clk);
         low = low | (o_txd !== 1'b1);
      end
      chk("txd held", 32'h0, {31'h0, low});
      chk("blue idle", 32'(f0), 32'(blue_flips));
      rd(sapc_pkg::ADDR_STATUS, d);
      chk("status full", 32'h80, d);
      stall <= 1'b0;
      n = 0;
      while (rx_cnt < 8'h04 && n < 2000) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 2000) begin
         $display("MISMATCH frames expected 4 seen %0d", rx_cnt);
         error_cnt++;
         end_of_test();
      end
      cycles(200);
      chk("frames", 32'h4, {24'h0, rx_cnt});
      chk("bytes", 32'ha0a1a2a3, rx_bytes);
      chk("stop bits", 32'h0, {24'h0, rx_bad});
      chk("blue flicker", 32'h1, {31'h0, (blue_flips - f0) >= 16});
      rd(sapc_pkg::ADDR_STATUS, d);
      chk("status empty", 32'hd0, d);
      $display("test transmit done");
   endtask
   initial begin
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 32'h0;
      i_sw0_n = 1'b1;
      sw1_drv = 1'b1;
      stall = 1'b0;
      blue_prev = 1'b1;
      error_cnt = 0;
      n_tests = 0;
      blue_flips = 0;
      cycles(2);
      i_rst_n <= 1'b1;
      t_reset();
      t_switch();
      t_leds();
      t_tx();
      end_of_test();
   end
endmodule
